// ===== ctls_core.sv
`timescale 1ns/1ps
module ctls_core
   import ctls_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // Configuration from the image size and coding style segments
   input  wire ctls_cfg_t cfg_i,
   // Forward path, samples in and coefficients out
   input  wire ctls_smp_t  fwd_i,
   output ctls_coef_t      fwd_o,
   // Reconstruction path, coefficients in and samples out
   input  wire ctls_coef_t inv_i,
   output ctls_smp_t       inv_o,
   // Status
   output logic            cfg_err_o
);

   function automatic logic signed [IW-1:0] lshift(input logic [SW-1:0] s,
                                                   input logic [7:0]    sz);
      logic signed [IW-1:0] off;
      off = IW'(1) << sz[DEPTH_MSB:0];
      if (sz[SIGN_BIT])
         lshift = IW'($signed(s));
      else
         lshift = $signed({{(IW-SW){1'b0}}, s}) - off;
   endfunction

   function automatic logic signed [AW-1:0] mac3(input logic signed [AW-1:0] a,
                                                 input logic signed [AW-1:0] b,
                                                 input logic signed [AW-1:0] c,
                                                 input logic signed [15:0]   ka,
                                                 input logic signed [15:0]   kb,
                                                 input logic signed [15:0]   kc);
      logic signed [PW-1:0] acc;
      acc = PW'(a) * PW'(ka) + PW'(b) * PW'(kb) + PW'(c) * PW'(kc);
      acc = acc + (PW'(1) << (CF - 1));
      mac3 = AW'(acc >>> CF);
   endfunction

   // Saturation guards against quantisation pushing samples past the original range.
   function automatic logic [SW-1:0] unshift(input logic signed [AW-1:0] v,
                                             input logic [7:0]           sz);
      logic signed [AW-1:0] off;
      logic signed [AW-1:0] hi;
      logic signed [AW-1:0] lo;
      logic signed [AW-1:0] w;
      off = AW'(1) << sz[DEPTH_MSB:0];
      if (sz[SIGN_BIT]) begin
         w  = v;
         hi = off - AW'(1);
         lo = -off;
      end else begin
         w  = v + off;
         hi = (off <<< 1) - AW'(1);
         lo = '0;
      end
      if (w > hi)
         unshift = SW'(hi);
      else if (w < lo)
         unshift = SW'(lo);
      else
         unshift = SW'(w);
   endfunction

   logic       cfg_bad;
   ctls_xsel_t xs0;

   always_comb begin
      cfg_bad = ((cfg_i.xsel == CTLS_XF_REV) && !cfg_i.wave_rev)
             || ((cfg_i.xsel == CTLS_XF_IRR) && cfg_i.wave_rev)
             || ((cfg_i.xsel != CTLS_XF_NONE)
                 && ((cfg_i.ncomp < NCOMP_MIN) || !cfg_i.uniform));
      // A bad pairing falls back to plain pass-through rather than garbage.
      xs0 = cfg_bad ? CTLS_XF_NONE : cfg_i.xsel;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         cfg_err_o <= 1'b0;
      else
         cfg_err_o <= cfg_bad;
   end

   // Forward stage 1: level shift ahead of any transform.
   logic                       f1_v;
   ctls_xsel_t                 f1_xs;
   logic signed [2:0][IW-1:0]  f1;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         f1_v  <= 1'b0;
         f1_xs <= CTLS_XF_NONE;
         f1    <= '0;
      end else begin
         f1_v  <= fwd_i.valid;
         f1_xs <= xs0;
         for (int k = 0; k < 3; k++)
            f1[k] <= lshift(fwd_i.s[k], cfg_i.size[k]);
      end
   end

   // Forward stage 2: component transform.
   logic signed [2:0][IW-1:0] next_fwd;
   logic signed [AW-1:0]      a0;
   logic signed [AW-1:0]      a1;
   logic signed [AW-1:0]      a2;

   always_comb begin
      // Packed slices read as unsigned, so the sign is restored before widening.
      a0 = AW'($signed(f1[0]));
      a1 = AW'($signed(f1[1]));
      a2 = AW'($signed(f1[2]));
      case (f1_xs)
         CTLS_XF_REV: begin
            next_fwd[0] = IW'((a0 + (a1 <<< 1) + a2) >>> 2);
            next_fwd[1] = IW'(a2 - a1);
            next_fwd[2] = IW'(a0 - a1);
         end
         CTLS_XF_IRR: begin
            next_fwd[0] = IW'(mac3(a0, a1, a2, K_Y_I0, K_Y_I1, K_Y_I2));
            next_fwd[1] = IW'(mac3(a0, a1, a2, -K_B_I0, -K_B_I1, K_HALF));
            next_fwd[2] = IW'(mac3(a0, a1, a2, K_HALF, -K_R_I1, -K_R_I2));
         end
         default: next_fwd = f1;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fwd_o <= '0;
      end else begin
         fwd_o.valid <= f1_v;
         fwd_o.c     <= next_fwd;
      end
   end

   // Reconstruction stage 1: inverse component transform.
   logic signed [2:0][AW-1:0] next_inv;
   logic signed [AW-1:0]      y0;
   logic signed [AW-1:0]      y1;
   logic signed [AW-1:0]      y2;
   logic signed [AW-1:0]      g1;

   always_comb begin
      y0 = AW'($signed(inv_i.c[0]));
      y1 = AW'($signed(inv_i.c[1]));
      y2 = AW'($signed(inv_i.c[2]));
      g1 = y0 - ((y2 + y1) >>> 2);
      case (xs0)
         CTLS_XF_REV: begin
            next_inv[1] = g1;
            next_inv[0] = y2 + g1;
            next_inv[2] = y1 + g1;
         end
         CTLS_XF_IRR: begin
            next_inv[0] = mac3(y0, y1, y2, K_ONE, 16'sh0000, K_INV_E);
            next_inv[1] = mac3(y0, y1, y2, K_ONE, -K_INV_F, -K_INV_G);
            next_inv[2] = mac3(y0, y1, y2, K_ONE, K_INV_H, 16'sh0000);
         end
         default: begin
            next_inv[0] = y0;
            next_inv[1] = y1;
            next_inv[2] = y2;
         end
      endcase
   end

   logic                      i1_v;
   logic [2:0][7:0]           i1_sz;
   logic signed [2:0][AW-1:0] i1;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         i1_v  <= 1'b0;
         i1_sz <= '0;
         i1    <= '0;
      end else begin
         i1_v  <= inv_i.valid;
         i1_sz <= cfg_i.size;
         i1    <= next_inv;
      end
   end

   // Reconstruction stage 2: inverse level shift and clamp after the transform.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         inv_o <= '0;
      end else begin
         inv_o.valid <= i1_v;
         for (int k = 0; k < 3; k++)
            inv_o.s[k] <= unshift(i1[k], i1_sz[k]);
      end
   end

   sequence s_fwd_out;
      ##2 fwd_o.valid;
   endsequence

   sequence s_inv_out;
      ##2 inv_o.valid;
   endsequence

   property p_fwd_latency;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fwd_i.valid |-> s_fwd_out;
   endproperty
   a_fwd_latency: assert property (p_fwd_latency) else $error("forward latency wrong");

   property p_inv_latency;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      inv_i.valid |-> s_inv_out;
   endproperty
   a_inv_latency: assert property (p_inv_latency) else $error("inverse latency wrong");

   property p_fwd_mid;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fwd_i.valid && xs0 == CTLS_XF_NONE && !cfg_i.size[0][SIGN_BIT]
         && fwd_i.s[0] == (SW'(1) << cfg_i.size[0][DEPTH_MSB:0])
      |-> s_fwd_out ##0 fwd_o.c[0] == '0;
   endproperty
   a_fwd_mid: assert property (p_fwd_mid) else $error("level shift wrong");

   property p_rct_diff;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fwd_i.valid && xs0 == CTLS_XF_REV && !cfg_i.size[0][SIGN_BIT]
      |-> ##2 $signed(fwd_o.c[1]) == $past($signed({2'b00, fwd_i.s[2]})
                                          - $signed({2'b00, fwd_i.s[1]}), 2);
   endproperty
   a_rct_diff: assert property (p_rct_diff) else $error("reversible difference wrong");

   property p_rev_pair;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      cfg_i.xsel == CTLS_XF_REV && !cfg_i.wave_rev |=> cfg_err_o;
   endproperty
   a_rev_pair: assert property (p_rev_pair) else $error("reversible pairing not flagged");

   property p_irr_pair;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      cfg_i.xsel == CTLS_XF_IRR && cfg_i.wave_rev |=> cfg_err_o;
   endproperty
   a_irr_pair: assert property (p_irr_pair) else $error("irreversible pairing not flagged");

   property p_ncomp;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      cfg_i.xsel != CTLS_XF_NONE && cfg_i.ncomp < NCOMP_MIN |=> cfg_err_o;
   endproperty
   a_ncomp: assert property (p_ncomp) else $error("too few components not flagged");

   property p_inv_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      inv_i.valid && xs0 == CTLS_XF_REV && inv_i.c == '0 && !cfg_i.size[0][SIGN_BIT]
      |-> s_inv_out ##0 inv_o.s[0] == $past(SW'(1) << cfg_i.size[0][DEPTH_MSB:0], 2);
   endproperty
   a_inv_zero: assert property (p_inv_zero) else $error("inverse zero point wrong");

   property p_clamp;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      inv_i.valid && xs0 == CTLS_XF_NONE && inv_i.c[0] == 18'h1FFFF
         && !cfg_i.size[0][SIGN_BIT]
      |-> ##2 inv_o.s[0] == $past((SW'(2) << cfg_i.size[0][DEPTH_MSB:0]) - SW'(1), 2);
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp to range wrong");

   property p_fwd_quiet;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !fwd_i.valid |-> ##2 !fwd_o.valid;
   endproperty
   a_fwd_quiet: assert property (p_fwd_quiet) else $error("forward valid without input");

   property p_inv_quiet;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !inv_i.valid |-> ##2 !inv_o.valid;
   endproperty
   a_inv_quiet: assert property (p_inv_quiet) else $error("inverse valid without input");

   property p_rct_sum;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fwd_i.valid && xs0 == CTLS_XF_REV && !cfg_i.size[0][SIGN_BIT]
      |-> s_fwd_out ##0 fwd_o.c[0] == $past(IW'(({2'b00, fwd_i.s[0]}
                                               + {1'b0, fwd_i.s[1], 1'b0}
                                               + {2'b00, fwd_i.s[2]}) >> 2)
                                          - (IW'(1) << cfg_i.size[0][DEPTH_MSB:0]), 2);
   endproperty
   a_rct_sum: assert property (p_rct_sum) else $error("reversible first output wrong");

   property p_fwd_signed;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fwd_i.valid && xs0 == CTLS_XF_NONE && cfg_i.size[1][SIGN_BIT]
      |-> s_fwd_out ##0 fwd_o.c[1] == $past(IW'($signed(fwd_i.s[1])), 2);
   endproperty
   a_fwd_signed: assert property (p_fwd_signed) else $error("signed lane shifted");

   property p_uniform;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      cfg_i.xsel != CTLS_XF_NONE && !cfg_i.uniform |=> cfg_err_o;
   endproperty
   a_uniform: assert property (p_uniform) else $error("mixed depths not flagged");

   property p_no_xform;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      cfg_i.xsel == CTLS_XF_NONE |=> !cfg_err_o;
   endproperty
   a_no_xform: assert property (p_no_xform) else $error("plain path flagged");

   property p_signed_clamp;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      inv_i.valid && xs0 == CTLS_XF_NONE && cfg_i.size[1][SIGN_BIT]
         && $signed(inv_i.c[1]) >= $signed(IW'(1) << cfg_i.size[1][DEPTH_MSB:0])
      |-> s_inv_out ##0
          inv_o.s[1] == $past((SW'(1) << cfg_i.size[1][DEPTH_MSB:0]) - SW'(1), 2);
   endproperty
   a_signed_clamp: assert property (p_signed_clamp) else $error("signed clamp wrong");

endmodule

// ===== ctls_pkg.sv
// How it works
// - Forward samples of an unsigned component lose two to the power (depth minus one).
// - Reconstructed unsigned samples gain that same offset; signed ones pass unshifted.
// - The forward shift runs in the stage before the component transform, or alone.
// - Forward reversible first output is the floor of (I0 + 2*I1 + I2) / 4.
// - Forward reversible outputs I2 - I1 and I0 - I1 keep one extra bit of precision.
// - Inverse reversible gives I1 = Y0 - floor((Y2 + Y1) / 4), I0 = Y2 + I1, I2 = Y1 + I1.
// - The reversible transform with a non-reversible wavelet is a configuration error.
// - A transform needs three or more components of one depth without sub-sampling.
// - The transform applied is picked by a selection taken from the coding style.
// - The irreversible transform needs the irreversible wavelet and three components.
// - Forward irreversible first output is the luminance weighted sum of I0, I1, I2.
// - Forward irreversible second and third outputs use the listed chroma weights.
// - Inverse irreversible outputs use the listed weights on Y1 and Y2.
// - Irreversible weights are held in a fixed-point format of our own precision.
// - Reconstruction runs the inverse transform first and the inverse shift after it.
package ctls_pkg;
   localparam int SW        = 16;
   localparam int IW        = 18;
   localparam int AW        = 20;
   localparam int PW        = 36;
   localparam int CF        = 14;
   localparam int LAT       = 2;
   localparam int SIGN_BIT  = 7;
   localparam int DEPTH_MSB = 6;
   localparam logic [15:0] NCOMP_MIN = 16'h0003;
   // Weights in signed Q2.14; the precision is a free choice.
   localparam logic signed [15:0] K_ONE  = 16'sh4000;
   localparam logic signed [15:0] K_Y_I0 = 16'sh1323;
   localparam logic signed [15:0] K_Y_I1 = 16'sh2591;
   localparam logic signed [15:0] K_Y_I2 = 16'sh0937;
   localparam logic signed [15:0] K_B_I0 = 16'sh0ACD;
   localparam logic signed [15:0] K_B_I1 = 16'sh1533;
   localparam logic signed [15:0] K_HALF = 16'sh2000;
   localparam logic signed [15:0] K_R_I1 = 16'sh1ACC;
   localparam logic signed [15:0] K_R_I2 = 16'sh0534;
   localparam logic signed [15:0] K_INV_E = 16'sh59BA;
   localparam logic signed [15:0] K_INV_F = 16'sh1606;
   localparam logic signed [15:0] K_INV_G = 16'sh2DB5;
   localparam logic signed [15:0] K_INV_H = 16'sh7168;

   typedef enum logic [1:0] {CTLS_XF_NONE, CTLS_XF_REV, CTLS_XF_IRR} ctls_xsel_t;

   typedef struct packed {
      ctls_xsel_t       xsel;
      logic             wave_rev;
      logic             uniform;
      logic [15:0]      ncomp;
      logic [2:0][7:0]  size;
   } ctls_cfg_t;

   typedef struct packed {
      logic               valid;
      logic [2:0][SW-1:0] s;
   } ctls_smp_t;

   typedef struct packed {
      logic               valid;
      logic [2:0][IW-1:0] c;
   } ctls_coef_t;
endpackage

// ===== ctls_wave_model.sv
`timescale 1ns/1ps
module ctls_wave_model
   import ctls_pkg::*;
(
   // Clock and request from the bench
   input  wire logic               core_clk_i,
   input  wire logic               req_i,
   input  wire logic [2:0][IW-1:0] req_c_i,
   // Coefficients toward the block
   output ctls_coef_t              inv_o
);
   initial inv_o = '0;
   // Between beats the lanes invert on every falling edge, so they alternate between the last word and its inverse.
   always @(negedge core_clk_i) begin
      inv_o.valid <= req_i;
      inv_o.c     <= req_i ? req_c_i : ~inv_o.c;
   end
endmodule

// ===== component_transform_level_shift_tb_top.sv
`timescale 1ns/1ps
module component_transform_level_shift_tb_top
   import ctls_pkg::*;
;
   logic               core_clk_i;
   logic               rst_n_i;
   ctls_cfg_t          cfg_i;
   ctls_smp_t          fwd_i;
   ctls_coef_t         fwd_o;
   ctls_coef_t         inv_i;
   ctls_smp_t          inv_o;
   logic               cfg_err_o;
   logic               req;
   logic [2:0][IW-1:0] req_c;
   int                 bad_count;
   int                 compares;
   int                 cycles;

   ctls_core ctls_core_inst (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .cfg_i      (cfg_i),
      .fwd_i      (fwd_i),
      .fwd_o      (fwd_o),
      .inv_i      (inv_i),
      .inv_o      (inv_o),
      .cfg_err_o  (cfg_err_o)
   );
   ctls_wave_model ctls_wave_model_inst (
      .core_clk_i (core_clk_i),
      .req_i      (req),
      .req_c_i    (req_c),
      .inv_o      (inv_i)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   task automatic report_and_stop;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // The tests need about 42 cycles; this ceiling only cuts a hang short.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         report_and_stop;
      end
   end

   task automatic fail(input string m);
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chk_bit(input logic g, input logic e);
      compares++;
      if (g !== e) fail("flag");
   endtask
   task automatic chk_coef(input logic [IW-1:0] g, input logic [IW-1:0] e);
      compares++;
      if (g !== e) fail($sformatf("coef %h expected %h", g, e));
   endtask
   task automatic chk_smp(input logic [SW-1:0] g, input logic [SW-1:0] e);
      compares++;
      if (g !== e) fail($sformatf("sample %h expected %h", g, e));
   endtask
   task automatic chk_near(input logic signed [IW-1:0] g, input real e);
      real d;
      compares++;
      d = $itor(g) - e;
      if ((^g === 1'bx) || d > 1.0 || d < -1.0) fail($sformatf("%0d near %f", g, e));
   endtask
   task automatic chk3(input ctls_coef_t r, input int e0, e1, e2);
      chk_coef(r.c[0], IW'(e0));
      chk_coef(r.c[1], IW'(e1));
      chk_coef(r.c[2], IW'(e2));
   endtask
   task automatic chk3s(input ctls_smp_t r, input int e0, e1, e2);
      chk_smp(r.s[0], SW'(e0));
      chk_smp(r.s[1], SW'(e1));
      chk_smp(r.s[2], SW'(e2));
   endtask

   function automatic ctls_cfg_t mk(ctls_xsel_t x, logic w, logic u, logic [15:0] n,
                                    logic [7:0] z);
      return '{x, w, u, n, {z, z, z}};
   endfunction

   task automatic run_fwd(input int a, b, c, output ctls_coef_t r);
      fwd_i.s     = {SW'(c), SW'(b), SW'(a)};
      fwd_i.valid = 1'b1;
      @(negedge core_clk_i);
      fwd_i.valid = 1'b0;
      fwd_i.s     = ~fwd_i.s;
      chk_bit(fwd_o.valid, 1'b0);
      @(negedge core_clk_i);
      chk_bit(fwd_o.valid, 1'b1);
      r = fwd_o;
   endtask
   task automatic run_inv(input int a, b, c, output ctls_smp_t r);
      req   <= 1'b1;
      req_c <= {IW'(c), IW'(b), IW'(a)};
      @(negedge core_clk_i);
      req <= 1'b0;
      @(negedge core_clk_i);
      chk_bit(inv_o.valid, 1'b0);
      @(negedge core_clk_i);
      chk_bit(inv_o.valid, 1'b1);
      r = inv_o;
   endtask

   task automatic t_none;
      ctls_coef_t r;
      ctls_smp_t  s;
      cfg_i = mk(CTLS_XF_NONE, 1'b1, 1'b1, 16'h0003, 8'h07);
      run_fwd(128, 0, 255, r);
      chk3(r, 0, -128, 127);
      run_inv(131071, -200, 5, s);
      chk3s(s, 255, 0, 133);
      cfg_i = mk(CTLS_XF_NONE, 1'b1, 1'b1, 16'h0003, 8'h87);
      run_fwd(-5, 100, -128, r);
      chk3(r, -5, 100, -128);
      run_inv(-5, 200, -300, s);
      chk3s(s, -5, 127, -128);
   endtask

   task automatic t_rev;
      ctls_coef_t r;
      ctls_smp_t  s;
      cfg_i = mk(CTLS_XF_REV, 1'b1, 1'b1, 16'h0003, 8'h07);
      @(negedge core_clk_i);
      chk_bit(cfg_err_o, 1'b0);
      run_fwd(0, 255, 3, r);
      chk3(r, 0, -252, -255);
      run_fwd(0, 0, 1, r);
      chk3(r, -128, 1, 0);
      run_inv(0, -252, -255, s);
      chk3s(s, 0, 255, 3);
      run_inv(0, 0, 0, s);
      chk3s(s, 128, 128, 128);
      cfg_i = mk(CTLS_XF_REV, 1'b1, 1'b1, 16'h0003, 8'h0F);
      run_fwd(0, 65535, 0, r);
      chk3(r, -1, -65535, -65535);
   endtask

   task automatic t_irr;
      ctls_coef_t r;
      ctls_smp_t  s;
      cfg_i = mk(CTLS_XF_IRR, 1'b0, 1'b1, 16'h0003, 8'h07);
      run_fwd(200, 100, 50, r);
      chk_near(r.c[0], 0.299 * 72 - 0.587 * 28 - 0.144 * 78);
      chk_near(r.c[1], -0.16875 * 72 + 0.33126 * 28 - 0.5 * 78);
      chk_near(r.c[2], 0.5 * 72 + 0.41869 * 28 + 0.08131 * 78);
      run_inv(10, 20, -30, s);
      chk_near({2'b00, s.s[0]}, 138.0 - 1.402 * 30);
      chk_near({2'b00, s.s[1]}, 138.0 - 0.34413 * 20 + 0.71414 * 30);
      chk_near({2'b00, s.s[2]}, 138.0 + 1.772 * 20);
   endtask

   task automatic t_err;
      ctls_cfg_t  bad [4];
      ctls_coef_t r;
      bad[0] = mk(CTLS_XF_REV, 1'b0, 1'b1, 16'h0003, 8'h07);
      bad[1] = mk(CTLS_XF_IRR, 1'b1, 1'b1, 16'h0003, 8'h07);
      bad[2] = mk(CTLS_XF_REV, 1'b1, 1'b1, 16'h0002, 8'h07);
      bad[3] = mk(CTLS_XF_IRR, 1'b0, 1'b0, 16'h0003, 8'h07);
      foreach (bad[i]) begin
         cfg_i = bad[i];
         @(negedge core_clk_i);
         chk_bit(cfg_err_o, 1'b1);
         run_fwd(0, 255, 3, r);
         chk3(r, -128, 127, -125);
      end
   endtask

   initial begin
      bad_count = 0;
      compares  = 0;
      cycles    = 0;
      rst_n_i   = 1'b0;
      cfg_i     = '0;
      fwd_i     = '0;
      req       = 1'b0;
      req_c     = '0;
      repeat (2) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      t_none;
      t_rev;
      t_irr;
      t_err;
      report_and_stop;
   end
endmodule
